// ==== ashp_host_model.sv ====
// Processor model: chip enable, strobes, selects and the write side of the data bus.
// Assumes the bench calls cycle() and that pins change only at falling clock edges.
`timescale 1ns/1ps
module ashp_host_model (
   input  wire logic       sys_clk,           // Device clock, pacing only.
   input  wire logic [7:0] data_out,          // Device bus output side.
   input  wire logic       data_oe,           // Device bus output enable.
   output logic            chip_enable_n,     // Chip enable pin.
   output logic            read_n,            // Read strobe pin.
   output logic            write_n,           // Write strobe pin.
   output logic            irq_acknowledge_n, // Acknowledge pin.
   output logic            chan_sel,          // Channel select pin.
   output logic            data_ctrl_sel,     // Data/control select pin.
   output logic      [7:0] data_in            // Resolved bus level.
);
   logic [7:0] host_d;
   // Released bus shows the inverse of the last value, so a stale byte never matches.
   assign data_in = data_oe ? data_out : host_d;
   initial begin
      {chip_enable_n, read_n, write_n, irq_acknowledge_n} = 4'hf;
      {chan_sel, data_ctrl_sel} = 2'h0;
      host_d = 8'h5a;
   end
   task automatic cycle(input bit wr, input bit ack, input bit ce, input bit ch, input bit dc,
                        input logic [7:0] wd, input int low, input int post);
      @(negedge sys_clk);
      chan_sel          = ch;
      data_ctrl_sel     = dc;
      irq_acknowledge_n = !ack;
      chip_enable_n     = !ce;
      if (wr) host_d = ~wd;
      if (ack) repeat (3) @(negedge sys_clk);
      if (wr) write_n = 1'b0;
      else read_n = 1'b0;
      // Write data turns valid only for the last low clock, then holds past the rise.
      repeat (low - 1) @(negedge sys_clk);
      if (wr) host_d = wd;
      @(negedge sys_clk);
      {read_n, write_n} = 2'h3;
      repeat (post) @(negedge sys_clk);
      chip_enable_n     = 1'b1;
      irq_acknowledge_n = 1'b1;
      if (wr) host_d = ~wd;
   endtask
endmodule

// ==== ashp_pkg.sv ====
// Package for the asynchronous strobe host port: timing counts and widths.
// Assumes a single 100 MHz device clock drives every user of these constants.
package ashp_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned RECOVERY_CLOCKS = 4;
   localparam int unsigned SYNC_STAGES     = 2;
   localparam int unsigned DATA_W          = 8;
   localparam int unsigned VEC_NOVEC_BIT   = 1;
   localparam logic [7:0]  VECTOR_RESET    = 8'h00;
   localparam logic [2:0]  REC_CNT_RESET   = 3'h0;
endpackage

// ==== ashp_port.sv ====
// Host port of a dual-channel serial controller: strobe synchronisation, register
// read and write controls, access recovery timing and interrupt-acknowledge claim.
// Assumes the processor strobes are asynchronous to sys_clk and the data bus wire
// is resolved outside from data_oe.
`timescale 1ns/1ps

// Notes on behaviour
// (RULE_01) Host spaces own accesses four clocks apart.
// (RULE_02) Recovery counts only this device's accesses.
// (RULE_03) Host holds selects steady through each cycle.
// (RULE_04) Access is chip enable overlapped with strobe.
// (RULE_05) Write data captured near strobe end.
// (RULE_06) Host lets daisy chain settle before read.
// (RULE_07) Claim acknowledge if pending and priority high.
// (RULE_08) Drive vector on bus during claimed acknowledge.
// (RULE_09) Set in-service latch of acknowledged source.
// (RULE_10) Vector suppressed when control bit one set.
// (RULE_11) Strobes pass multi-stage synchroniser first.
// (RULE_12) Data bus driven only on reads or claims.
module ashp_port #(
   parameter int unsigned NUM_SRC = 6  // Interrupt sources, highest priority at bit 0.
) (
   input  wire logic               sys_clk,             // Device clock, 100 MHz.
   input  wire logic               rst_n,               // Synchronous reset, active low.
   input  wire logic               chip_enable_n,       // Chip enable pin, active low.
   input  wire logic               read_n,              // Read strobe pin, active low.
   input  wire logic               write_n,             // Write strobe pin, active low.
   input  wire logic               irq_acknowledge_n,   // Acknowledge pin, active low.
   input  wire logic               chan_sel,            // Channel select pin.
   input  wire logic               data_ctrl_sel,       // Data/control select pin.
   input  wire logic               priority_in,         // Daisy-chain priority input.
   input  wire logic [7:0]         data_in,             // Data bus input side.
   output logic      [7:0]         data_out,            // Data bus output side.
   output logic                    data_oe,             // Data bus output enable.
   output logic                    priority_out,        // Daisy-chain priority output.
   output logic                    irq_n,               // Interrupt request, active low.
   output logic                    reg_wr,              // Register write pulse.
   output logic                    reg_rd,              // Register read pulse.
   output logic                    reg_chan,            // Channel of the access.
   output logic                    reg_data_sel,        // Data/control of the access.
   output logic      [7:0]         reg_wdata,           // Captured write data.
   input  wire logic [7:0]         reg_rdata,           // Read data from registers.
   input  wire logic [NUM_SRC-1:0] irq_pending,         // Pending sources, same clock.
   input  wire logic [7:0]         irq_vector,          // Vector for the highest source.
   input  wire logic [7:0]         master_interrupt_control, // Master control register.
   output logic      [NUM_SRC-1:0] in_service_latch,    // In-service latches.
   input  wire logic [NUM_SRC-1:0] in_service_clear,    // Clear pulses per source.
   output logic                    recovery_violation   // Access came too soon, pulse.
);
   localparam int unsigned RECOV = ashp_pkg::RECOVERY_CLOCKS;

   if (NUM_SRC < 1 || NUM_SRC > 8) begin : g_bad_num_src
      $error("ashp_port supports 1 to 8 sources");
   end

   // ------------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------------
   logic [5:0] pins_sync;
   logic       ce_s, rd_s, wr_s, ack_s, chan_s, dsel_s;

   ashp_sync #(
      .WIDTH  (6),
      .STAGES (ashp_pkg::SYNC_STAGES)
   ) u_sync (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .async_in  ({chip_enable_n, read_n, write_n, irq_acknowledge_n, chan_sel, data_ctrl_sel}),
      .reset_val (6'h3c),
      .sync_out  (pins_sync)
   ); // RULE_11

   assign {ce_s, rd_s, wr_s, ack_s, chan_s, dsel_s} = pins_sync;

   // Priority input is synchronised too; it is sampled when the read strobe falls.
   logic pri_m;
   logic pri_s;
   logic [7:0] wdata_m;
   logic [7:0] wdata_s;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pri_m   <= 1'b0;
         pri_s   <= 1'b0;
         wdata_m <= 8'h00;
         wdata_s <= 8'h00;
      end else begin
         pri_m   <= priority_in;
         pri_s   <= pri_m;
         wdata_m <= data_in;
         wdata_s <= wdata_m;
      end
   end

   // ------------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------------
   // The effective read and write strobes are the overlap of chip enable and strobe; acknowledge overlaps read.
   logic rd_act, wr_act, ack_act;
   assign ack_act = !ack_s && !rd_s;                  // RULE_04
   assign rd_act  = !ce_s && !rd_s && ack_s;          // RULE_04
   assign wr_act  = !ce_s && !wr_s && ack_s;          // RULE_04

   logic rd_prev, wr_prev, ack_prev;
   logic rd_fall, wr_fall, wr_rise, ack_fall, any_fall;
   assign rd_fall  = rd_act && !rd_prev;
   assign wr_fall  = wr_act && !wr_prev;
   assign wr_rise  = !wr_act && wr_prev;
   assign ack_fall = ack_act && !ack_prev;
   assign any_fall = rd_fall || wr_fall || ack_fall;

   // ------------------------------------------------------------------
   // State: recovery, acknowledge claim, outputs
   // ------------------------------------------------------------------
   logic [2:0]         rec_cnt, next_rec_cnt;
   logic               claim, next_claim;
   logic               novec, next_novec;
   logic [7:0]         vec_hold, next_vec_hold;
   logic [NUM_SRC-1:0] next_isl;
   logic [7:0]         next_data_out, next_wdata;
   logic               next_reg_wr, next_reg_rd, next_viol;
   logic               next_chan, next_dsel;
   logic               has_pending;
   logic [NUM_SRC-1:0] top_src;

   // Lowest index is highest priority; one-hot pick of the winner.
   always_comb begin
      top_src = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (irq_pending[i] && !in_service_latch[i]) begin
            top_src = '0;
            top_src[i] = 1'b1;
         end
      end
   end
   assign has_pending = |top_src;

   always_comb begin
      next_rec_cnt  = (rec_cnt != 3'h0) ? rec_cnt - 3'h1 : rec_cnt;
      next_claim    = claim && ack_act;
      next_novec    = novec;
      next_vec_hold = vec_hold;
      next_isl      = (in_service_latch & ~in_service_clear);
      next_data_out = data_out;
      next_wdata    = reg_wdata;
      next_reg_wr   = 1'b0;
      next_reg_rd   = 1'b0;
      next_viol     = 1'b0;
      next_chan     = reg_chan;
      next_dsel     = reg_data_sel;
      // Reads and writes touch the counter only with chip enable set; acknowledge cycles reach it without chip enable.
      if (any_fall) begin
         next_rec_cnt = 3'(RECOV - 1);                          // RULE_02
         next_viol    = (rec_cnt != 3'h0);                      // RULE_01
      end
      if (rd_fall) begin
         next_reg_rd   = 1'b1;
         next_chan     = chan_s;
         next_dsel     = dsel_s;
         next_data_out = reg_rdata;
      end
      // Data is taken as the strobe ends, not while it is still low.
      if (wr_rise) begin
         next_reg_wr = 1'b1;                                    // RULE_05
         next_wdata  = wdata_s;                                 // RULE_05
      end
      if (wr_fall) begin
         next_chan = chan_s;
         next_dsel = dsel_s;
      end
      if (ack_fall && has_pending && pri_s) begin
         next_claim    = 1'b1;                                  // RULE_07
         next_isl      = next_isl | top_src;                    // RULE_09
         next_novec    = master_interrupt_control[ashp_pkg::VEC_NOVEC_BIT]; // RULE_10
         next_vec_hold = irq_vector;
         next_data_out = irq_vector;                            // RULE_08
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rec_cnt          <= ashp_pkg::REC_CNT_RESET;
         claim            <= 1'b0;
         novec            <= 1'b0;
         vec_hold         <= ashp_pkg::VECTOR_RESET;
         in_service_latch <= '0;
         data_out         <= 8'h00;
         reg_wdata        <= 8'h00;
         reg_wr           <= 1'b0;
         reg_rd           <= 1'b0;
         recovery_violation <= 1'b0;
         reg_chan         <= 1'b0;
         reg_data_sel     <= 1'b0;
         rd_prev          <= 1'b0;
         wr_prev          <= 1'b0;
         ack_prev         <= 1'b0;
      end else begin
         rec_cnt          <= next_rec_cnt;
         claim            <= next_claim;
         novec            <= next_novec;
         vec_hold         <= next_vec_hold;
         in_service_latch <= next_isl;
         data_out         <= next_data_out;
         reg_wdata        <= next_wdata;
         reg_wr           <= next_reg_wr;
         reg_rd           <= next_reg_rd;
         recovery_violation <= next_viol;
         reg_chan         <= next_chan;
         reg_data_sel     <= next_dsel;
         rd_prev          <= rd_act;
         wr_prev          <= wr_act;
         ack_prev         <= ack_act;
      end
   end

   // Bus is released the moment the strobe is seen high again.
   assign data_oe      = (rd_act && rd_prev) || (claim && ack_act && !novec); // RULE_12 RULE_08 RULE_10
   // A device with a pending source blocks lower devices in the chain.
   // The synchronised level is used, so the chain passes priority two clocks late.
   assign priority_out = pri_s && !has_pending && !(|in_service_latch);
   assign irq_n        = !(has_pending && pri_s);

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   AST_WR_ON_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_05
      (wr_prev && !wr_act) |=> (reg_wr && reg_wdata == $past(wdata_s)))
      else $error("write not captured at strobe end");
   AST_NO_WR_EARLY: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_04
      (ce_s || wr_s) && !wr_prev |=> !reg_wr)
      else $error("write without overlapped strobe");
   AST_CLAIM: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_07
      (ack_fall && has_pending && pri_s) |=> claim)
      else $error("acknowledge not claimed");
   AST_NO_CLAIM: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_07
      (ack_fall && !pri_s && !claim) |=> !claim)
      else $error("claimed without priority");
   AST_ISL_SET: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_09
      (ack_fall && has_pending && pri_s) |=> ((in_service_latch & $past(top_src)) != '0))
      else $error("in-service latch not set");
   AST_VECTOR: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_08
      (claim && ack_act && !novec) |-> (data_oe && data_out == vec_hold))
      else $error("vector not driven");
   AST_NOVEC: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_10
      (claim && novec && !rd_act) |-> !data_oe)
      else $error("vector driven while suppressed");
   AST_OE_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_12
      (!rd_act && !(claim && ack_act)) |-> !data_oe)
      else $error("bus driven when idle");
   AST_RECOVERY: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_02
      any_fall |=> (rec_cnt == 3'(RECOV - 1)) ##1 (rec_cnt == 3'(RECOV - 2) || $past(any_fall)))
      else $error("recovery count not restarted");
endmodule

// ==== ashp_sync.sv ====
// Multi-stage synchroniser for a group of asynchronous pin levels.
// Assumes the inputs come from outside the sys_clk domain.
`timescale 1ns/1ps
module ashp_sync #(
   parameter int unsigned WIDTH  = 4,
   parameter int unsigned STAGES = 2
) (
   input  wire logic             sys_clk,   // Device clock.
   input  wire logic             rst_n,     // Synchronous reset, active low.
   input  wire logic [WIDTH-1:0] async_in,  // Raw pin levels.
   input  wire logic [WIDTH-1:0] reset_val, // Level held during reset (constant).
   output logic      [WIDTH-1:0] sync_out   // Synchronised levels.
);
   logic [WIDTH-1:0] stage [STAGES];
   logic [WIDTH-1:0] next_stage [STAGES];

   // A single stage leaves metastability straight into the logic, so it is refused.
   if (STAGES < 2) begin : g_bad_stages
      $error("ashp_sync needs at least two stages");
   end

   always_comb begin
      next_stage[0] = async_in;
      for (int i = 1; i < STAGES; i++) begin
         next_stage[i] = stage[i-1];
      end
   end

   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < STAGES; i++) begin
         if (!rst_n) begin
            stage[i] <= reset_val;
         end else begin
            stage[i] <= next_stage[i];
         end
      end
   end

   assign sync_out = stage[STAGES-1];
endmodule

// ==== async_strobe_host_port_tb.sv ====
// Self-checking bench for the host port: writes, reads, foreign cycles, acknowledges.
// Assumes ashp_pkg and the design files are compiled first.
`timescale 1ns/1ps
module async_strobe_host_port_tb;
   logic       sys_clk = 1'b0, rst_n = 1'b0, priority_in = 1'b1;
   logic       chip_enable_n, read_n, write_n, irq_acknowledge_n, chan_sel, data_ctrl_sel;
   logic [7:0] data_in, data_out, reg_wdata, reg_rdata = 8'h00, irq_vector = 8'h00, mic = 8'h00;
   logic       data_oe, priority_out, irq_n, reg_wr, reg_rd, reg_chan, reg_data_sel, viol;
   logic [5:0] irq_pending = 6'h00, isl, isc = 6'h00, exp_isl;
   logic [7:0] d, oe_data;
   bit         ch, dc, oe_seen, claim;
   int         n_mismatch, check_count, n_wr, n_rd, n_viol, w0, r0;
   always #5 sys_clk = ~sys_clk;
   ashp_host_model host (.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe),
      .chip_enable_n(chip_enable_n), .read_n(read_n), .write_n(write_n),
      .irq_acknowledge_n(irq_acknowledge_n), .chan_sel(chan_sel), .data_ctrl_sel(data_ctrl_sel),
      .data_in(data_in));
   ashp_port #(.NUM_SRC(6)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .chip_enable_n(chip_enable_n),
      .read_n(read_n), .write_n(write_n), .irq_acknowledge_n(irq_acknowledge_n),
      .chan_sel(chan_sel), .data_ctrl_sel(data_ctrl_sel), .priority_in(priority_in),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .priority_out(priority_out),
      .irq_n(irq_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_chan(reg_chan),
      .reg_data_sel(reg_data_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .irq_pending(irq_pending), .irq_vector(irq_vector), .master_interrupt_control(mic),
      .in_service_latch(isl), .in_service_clear(isc), .recovery_violation(viol));
   // ----------------------------------------------------------------------------------
   // Monitors and helpers
   // ----------------------------------------------------------------------------------
   // Sampled mid-cycle so that outputs launched at the rising edge have settled.
   always @(negedge sys_clk) begin
      if (reg_wr === 1'b1) n_wr++;
      if (reg_rd === 1'b1) n_rd++;
      if (viol === 1'b1) n_viol++;
      if (data_oe === 1'b1) begin
         oe_seen = 1'b1;
         oe_data = data_out;
      end
   end
   function automatic logic [5:0] top_src(input logic [5:0] p);
      return p & (~p + 6'h01);
   endfunction
   task automatic chk(input logic ok, input string what);
      check_count++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100000;
      n_mismatch++;
      test_done();
   end
   // ----------------------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------------------
   initial begin
      void'($urandom(67));
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk) rst_n = 1'b1;
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         ch = 1'($urandom_range(1));
         dc = 1'($urandom_range(1));
         w0 = n_wr;
         oe_seen = 1'b0;
         host.cycle(1, 0, 1, ch, dc, d, 2 + i % 3, 3);
         repeat (4) @(negedge sys_clk);
         chk(n_wr == w0 + 1, "one write pulse");
         chk(reg_wdata === d, "write data");
         chk(reg_chan === ch && reg_data_sel === dc, "write selects");
         chk(oe_seen == 1'b0, "bus driven on write");
         reg_rdata = 8'($urandom);
         r0 = n_rd;
         oe_seen = 1'b0;
         host.cycle(0, 0, 1, ch, dc, 8'h00, 4, 3);
         repeat (4) @(negedge sys_clk);
         chk(n_rd == r0 + 1 && oe_seen && oe_data === reg_rdata, "read data");
         oe_seen = 1'b0;
         host.cycle(i[0], 0, 0, ch, dc, d, 3, 3);
         repeat (4) @(negedge sys_clk);
         chk(n_rd == r0 + 1 && n_wr == w0 + 1 && !oe_seen, "foreign cycle taken");
      end
      w0 = n_viol;
      host.cycle(0, 0, 1, 0, 0, 8'h00, 1, 1);
      host.cycle(0, 0, 0, 0, 0, 8'h00, 1, 1);
      host.cycle(0, 0, 1, 0, 0, 8'h00, 1, 1);
      repeat (6) @(negedge sys_clk);
      chk(n_viol == w0, "foreign cycle restarted recovery");
      host.cycle(0, 0, 1, 0, 0, 8'h00, 1, 1);
      host.cycle(0, 0, 1, 0, 0, 8'h00, 1, 1);
      repeat (6) @(negedge sys_clk);
      chk(n_viol == w0 + 1 && w0 == 0, "recovery flag");
      for (int i = 0; i < 8; i++) begin
         @(negedge sys_clk) isc = 6'h3f;
         @(negedge sys_clk) isc = 6'h00;
         chk(priority_out === priority_in && irq_n === 1'b1, "idle priority chain");
         irq_pending = (i == 0) ? 6'h20 : 6'($urandom_range(63, 1));
         irq_vector = 8'($urandom);
         priority_in = (i != 3);
         mic = {6'h00, (i == 1) ? 1'b1 : (i == 2) ? 1'b0 : 1'($urandom_range(1)), 1'b0};
         claim = priority_in;
         oe_seen = 1'b0;
         host.cycle(0, 1, 0, 0, 0, 8'h00, 4, 3);
         repeat (4) @(negedge sys_clk);
         exp_isl = claim ? top_src(irq_pending) : 6'h00;
         chk(isl === (claim ? top_src(irq_pending) : 6'h00), "in-service latch");
         chk(oe_seen == (claim && !mic[1]), "vector drive");
         if (oe_seen) chk(oe_data === irq_vector, "vector value");
         chk(irq_n === !((irq_pending & ~exp_isl) != 6'h00 && priority_in), "interrupt request");
         chk(priority_out === 1'b0, "chain blocked while pending");
         irq_pending = 6'h00;
      end
      // Reset in mid-run with a latch set and stale write data, then a write right after release.
      rst_n = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk(isl === 6'h00 && reg_wdata === 8'h00 && !data_oe && irq_n === 1'b1 && !reg_wr, "reset values");
      rst_n = 1'b1;
      d = 8'($urandom);
      w0 = n_wr;
      host.cycle(1, 0, 1, 1, 1, d, 2, 3);
      repeat (4) @(negedge sys_clk);
      chk(n_wr == w0 + 1 && reg_wdata === d, "write after reset");
      test_done();
   end
endmodule
